// File: hw/icx_pkg.sv
// Shared constants, register map and bus carriers for the interrupt flag block.
package icx_pkg;

  // Bus and vector widths.
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int NSRC   = 16;
  localparam int NGPIO  = 17;
  localparam int PIN_W  = 5;
  localparam int ST_W   = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_PEND  = 16'h4600;
  localparam logic [15:0] IDX_MISS  = 16'h4602;
  localparam logic [15:0] IDX_GEN   = 16'h4618;
  localparam logic [15:0] IDX_CFG   = 16'h461A;
  localparam logic [15:0] IDX_SWT   = 16'h4638;
  localparam logic [15:0] IDX_STAT  = 16'h4700;
  localparam logic [15:0] IDX_SMASK = 16'h4702;
  localparam logic [15:0] IDX_REGC  = 16'h4704;

  // Byte addresses derived from the indices.
  localparam logic [ADDR_W-1:0] ADDR_PEND  = {2'b00, IDX_PEND, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MISS  = {2'b00, IDX_MISS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GEN   = {2'b00, IDX_GEN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CFG   = {2'b00, IDX_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SWT   = {2'b00, IDX_SWT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STAT  = {2'b00, IDX_STAT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SMASK = {2'b00, IDX_SMASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_REGC  = {2'b00, IDX_REGC, 2'b00};

  // Source bit positions in the pending and missed registers.
  localparam int BIT_WDOG   = 15;
  localparam int BIT_FAULT  = 14;
  localparam int BIT_TMR    = 13;
  localparam int BIT_GPIO   = 12;
  localparam int BIT_ADC    = 11;
  localparam int BIT_MACRX  = 10;
  localparam int BIT_MACTX  = 9;
  localparam int BIT_MACTMR = 8;
  localparam int BIT_SEC    = 7;
  localparam int BIT_SC2    = 6;
  localparam int BIT_SC1    = 5;
  localparam int BIT_SLEEP  = 4;
  localparam int BIT_BB     = 3;
  localparam int BIT_DBG    = 2;
  localparam int BIT_SW     = 1;

  // Bit masks: implemented bits, bits open to application code, level sources.
  localparam logic [NSRC-1:0] VALID_MASK   = 16'hFFFE;
  localparam logic [NSRC-1:0] APP_WR_MASK  = 16'h3860;
  localparam logic [NSRC-1:0] LEVEL_MASK   = 16'h1000;

  // Status register bits for the block's own interrupt output.
  localparam int ST_PEND_SET = 0;
  localparam int ST_MISS_SET = 1;
  localparam int ST_SW_TRIG  = 2;

  // Regulator control fields.
  localparam int RC_ALT_EN  = 0;
  localparam int RC_PIN_LSB = 4;

  // Reset values.
  localparam logic [NSRC-1:0]  RST_FLAGS = 16'h0000;
  localparam logic [ST_W-1:0]  RST_STAT  = 3'h0;
  localparam logic [PIN_W-1:0] RST_PIN   = 5'h00;

  // APB request from the master.
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } icx_apb_req_t;

  // APB response to the master.
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } icx_apb_rsp_t;

endpackage

// File: hw/icx_flag_cell.sv
// One source's pending bit and missed-event bit.
`timescale 1ns/10ps
module icx_flag_cell #(
  parameter bit IS_LEVEL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic event_in,
  input  wire logic enable_in,
  input  wire logic pend_clr_in,
  input  wire logic miss_clr_in,
  output logic      pend_out,
  output logic      miss_out,
  output logic      miss_hit_out
);

  logic pend_ff;
  logic miss_ff;
  logic nxt_pend;
  logic nxt_miss;

  // A repeat of an enabled pulse source while still pending is a miss; level sources hold instead.
  assign miss_hit_out = event_in & enable_in & pend_ff & ~IS_LEVEL;
  // The set term is ORed after the clear, so a coincident event keeps the bit.
  assign nxt_pend = event_in | (pend_ff & ~pend_clr_in);
  assign nxt_miss = miss_hit_out | (miss_ff & ~miss_clr_in);

  // Flag storage.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pend_ff <= 1'b0;
      miss_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      miss_ff <= nxt_miss;
    end
  end

  assign pend_out = pend_ff;
  assign miss_out = miss_ff;

  a_set_beats_clear: assert property (
    @(posedge clk_in) disable iff (srst_in) event_in && pend_clr_in |=> pend_ff)
    else $error("Pending bit lost when event met its clear.");

  a_clear_one_only: assert property (
    @(posedge clk_in) disable iff (srst_in)
    pend_ff && !pend_clr_in && !event_in |=> pend_ff)
    else $error("Pending bit dropped without a write of one.");

  a_repeat_sets_miss: assert property (
    @(posedge clk_in) disable iff (srst_in)
    pend_ff && event_in && enable_in && !IS_LEVEL |=> miss_ff && pend_ff)
    else $error("Repeated event did not record a miss.");

endmodule

// File: hw/icx_top.sv
// Top-level pending and missed-event flags, software trigger and regulator enable.
`timescale 1ns/10ps
module icx_top (
  input  wire logic                    CLOCK_IN,
  input  wire logic                    SRST_IN,
  input  wire icx_pkg::icx_apb_req_t   APB_REQ_IN,
  output icx_pkg::icx_apb_rsp_t        APB_RSP_OUT,
  input  wire logic [icx_pkg::NSRC-1:0] SRC_EVENT_IN,
  input  wire logic                    APP_MODE_IN,
  input  wire logic                    DEEP_SLEEP_IN,
  output logic                         CPU_IRQ_OUT,
  output logic                         INT_OUT,
  output logic                         REG_EN_OUT,
  output logic                         REG_EN_OE_N_OUT,
  output logic [icx_pkg::NGPIO-1:0]    REG_EN_PIN_SEL_OUT
);
  import icx_pkg::*;

  // Bus response flops.
  logic [DATA_W-1:0] prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;

  // Software visible state.
  logic [NSRC-1:0]   cfg_ff;
  logic              gen_ff;
  logic [NSRC-1:0]   swt_ff;
  logic [ST_W-1:0]   stat_ff;
  logic [ST_W-1:0]   smask_ff;
  logic              alt_en_ff;
  logic [PIN_W-1:0]  pin_ff;

  // Output flops.
  logic              cpu_irq_ff;
  logic              int_ff;
  logic              reg_en_ff;
  logic              oe_n_ff;
  logic [NGPIO-1:0]  pin_sel_ff;

  // Next values.
  logic [ST_W-1:0]   nxt_stat;
  logic [NSRC-1:0]   nxt_cfg;
  logic              nxt_pready;

  // Bus phase decode.
  wire               setup   = APB_REQ_IN.psel & ~APB_REQ_IN.penable;
  wire               access  = APB_REQ_IN.psel & APB_REQ_IN.penable & pready_ff;
  wire               wr_acc  = access & APB_REQ_IN.pwrite;
  wire               rd_acc  = access & ~APB_REQ_IN.pwrite;
  wire [NSRC-1:0]    wd      = APB_REQ_IN.pwdata[NSRC-1:0];

  // Address decode.
  wire               hit_pend  = APB_REQ_IN.paddr == ADDR_PEND;
  wire               hit_miss  = APB_REQ_IN.paddr == ADDR_MISS;
  wire               hit_gen   = APB_REQ_IN.paddr == ADDR_GEN;
  wire               hit_cfg   = APB_REQ_IN.paddr == ADDR_CFG;
  wire               hit_swt   = APB_REQ_IN.paddr == ADDR_SWT;
  wire               hit_stat  = APB_REQ_IN.paddr == ADDR_STAT;
  wire               hit_smask = APB_REQ_IN.paddr == ADDR_SMASK;
  wire               hit_regc  = APB_REQ_IN.paddr == ADDR_REGC;
  wire               mapped    = hit_pend | hit_miss | hit_gen | hit_cfg | hit_swt |
                                 hit_stat | hit_smask | hit_regc;

  // Application code may only touch the peripheral bits.
  wire [NSRC-1:0]    wr_mask   = APP_MODE_IN ? APP_WR_MASK : VALID_MASK;

  // Write-one-clear strobes for the flag cells.
  wire [NSRC-1:0]    pend_clr  = {NSRC{wr_acc & hit_pend}} & wd & wr_mask;
  wire [NSRC-1:0]    miss_clr  = {NSRC{wr_acc & hit_miss}} & wd & wr_mask;

  // Any write to the trigger register fires the software source, whatever the value.
  wire               sw_pulse  = wr_acc & hit_swt;

  // Event vector: the software position is driven only by the trigger.
  wire [NSRC-1:0]    ev_vec;
  assign ev_vec[NSRC-1:BIT_SW+1] = SRC_EVENT_IN[NSRC-1:BIT_SW+1];
  assign ev_vec[BIT_SW]          = sw_pulse;
  assign ev_vec[0]               = 1'b0;

  // Flag vectors gathered from the cells.
  wire [NSRC-1:0]    pend_vec;
  wire [NSRC-1:0]    miss_vec;
  wire [NSRC-1:0]    miss_hit;
  assign pend_vec[0] = 1'b0;
  assign miss_vec[0] = 1'b0;
  assign miss_hit[0] = 1'b0;

  // One flag cell per implemented source bit.
  genvar gi;
  generate
    for (gi = 1; gi < NSRC; gi++) begin : g_src
      icx_flag_cell #(
        .IS_LEVEL (LEVEL_MASK[gi])
      ) u_cell (
        .clk_in       (CLOCK_IN),
        .srst_in      (SRST_IN),
        .event_in     (ev_vec[gi]),
        .enable_in    (cfg_ff[gi]),
        .pend_clr_in  (pend_clr[gi]),
        .miss_clr_in  (miss_clr[gi]),
        .pend_out     (pend_vec[gi]),
        .miss_out     (miss_vec[gi]),
        .miss_hit_out (miss_hit[gi])
      );
    end
  endgenerate

  // Read multiplexer; unused high bits read as zero.
  wire [DATA_W-1:0]  rd_mux =
    hit_pend  ? {16'h0000, pend_vec} :
    hit_miss  ? {16'h0000, miss_vec} :
    hit_gen   ? {31'h00000000, gen_ff} :
    hit_cfg   ? {16'h0000, cfg_ff} :
    hit_swt   ? {16'h0000, swt_ff} :
    hit_stat  ? {29'h00000000, stat_ff} :
    hit_smask ? {29'h00000000, smask_ff} :
    hit_regc  ? {23'h000000, pin_ff, 3'h0, alt_en_ff} :
                32'h00000000;

  // Block events that set sticky status bits.
  wire [ST_W-1:0]    stat_set;
  assign stat_set[ST_PEND_SET] = |(ev_vec & ~pend_vec);
  assign stat_set[ST_MISS_SET] = |miss_hit;
  assign stat_set[ST_SW_TRIG]  = sw_pulse;

  // A status read clears only the bits it returned; new sets win over the clear.
  wire [ST_W-1:0]    stat_clr = (rd_acc & hit_stat) ? prdata_ff[ST_W-1:0] : RST_STAT;
  assign nxt_stat = (stat_ff & ~stat_clr) | stat_set;

  // Enable mask write keeps system-owned bits out of reach of application code.
  assign nxt_cfg = (wr_acc & hit_cfg) ? ((cfg_ff & ~wr_mask) | (wd & wr_mask)) : cfg_ff;

  // Ready rises for one cycle after each setup phase: no wait states.
  assign nxt_pready = setup & ~pready_ff;

  // Bus response: data and error are captured in the setup cycle.
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      if (setup) begin
        prdata_ff  <= rd_mux;
        pslverr_ff <= ~mapped;
      end
    end
  end

  // Control registers written by software.
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      cfg_ff    <= RST_FLAGS;
      gen_ff    <= 1'b0;
      swt_ff    <= RST_FLAGS;
      smask_ff  <= RST_STAT;
      alt_en_ff <= 1'b0;
      pin_ff    <= RST_PIN;
    end else begin
      cfg_ff <= nxt_cfg;
      if (wr_acc && hit_gen) begin
        gen_ff <= APB_REQ_IN.pwdata[0];
      end
      if (sw_pulse) begin
        swt_ff <= wd;
      end
      if (wr_acc && hit_smask) begin
        smask_ff <= APB_REQ_IN.pwdata[ST_W-1:0];
      end
      if (wr_acc && hit_regc) begin
        alt_en_ff <= APB_REQ_IN.pwdata[RC_ALT_EN];
        pin_ff    <= APB_REQ_IN.pwdata[RC_PIN_LSB +: PIN_W];
      end
    end
  end

  // Sticky status and the merged requests.
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      stat_ff    <= RST_STAT;
      cpu_irq_ff <= 1'b0;
      int_ff     <= 1'b0;
    end else begin
      stat_ff    <= nxt_stat;
      cpu_irq_ff <= gen_ff & (|(pend_vec & cfg_ff));
      int_ff     <= |(stat_ff & smask_ff);
    end
  end

  // Open-collector regulator enable: only ever pulled low, never driven high.
  wire               reg_pull = DEEP_SLEEP_IN & alt_en_ff;
  wire [NGPIO-1:0]   pin_one  = {{(NGPIO-1){1'b0}}, 1'b1} << pin_ff;

  // Regulator enable pin and its GPIO alternate-function select.
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      reg_en_ff  <= 1'b0;
      oe_n_ff    <= 1'b1;
      pin_sel_ff <= {NGPIO{1'b0}};
    end else begin
      reg_en_ff  <= 1'b0;
      oe_n_ff    <= ~reg_pull;
      pin_sel_ff <= alt_en_ff ? pin_one : {NGPIO{1'b0}};
    end
  end

  // Port drive.
  assign APB_RSP_OUT         = {prdata_ff, pready_ff, pslverr_ff};
  assign CPU_IRQ_OUT         = cpu_irq_ff;
  assign INT_OUT             = int_ff;
  assign REG_EN_OUT          = reg_en_ff;
  assign REG_EN_OE_N_OUT     = oe_n_ff;
  assign REG_EN_PIN_SEL_OUT  = pin_sel_ff;

  // Bus handshake steps.
  sequence s_setup;
    setup && !pready_ff;
  endsequence

  sequence s_ready_pulse;
    pready_ff ##1 !pready_ff;
  endsequence

  // Deep sleep entry steps: the pull request and the low line.
  sequence s_sleep_pull;
    DEEP_SLEEP_IN && alt_en_ff;
  endsequence

  sequence s_line_low;
    !oe_n_ff && !reg_en_ff;
  endsequence

  a_apb_ready_pulse: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) s_setup |=> s_ready_pulse)
    else $error("Ready did not pulse once after setup.");

  a_sw_trig_pend: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    sw_pulse |=> pend_vec[BIT_SW] && swt_ff == $past(wd) && stat_ff[ST_SW_TRIG])
    else $error("Trigger write did not set software pending.");

  a_app_wdog_kept: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    APP_MODE_IN && wr_acc && hit_pend && pend_vec[BIT_WDOG] |=> pend_vec[BIT_WDOG])
    else $error("Application write cleared a system pending bit.");

  a_app_miss_kept: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    APP_MODE_IN && wr_acc && hit_miss && miss_vec[BIT_MACRX] |=> miss_vec[BIT_MACRX])
    else $error("Application write cleared a system missed bit.");

  a_app_tmr_clear: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    wr_acc && hit_pend && wd[BIT_TMR] && !ev_vec[BIT_TMR] |=> !pend_vec[BIT_TMR])
    else $error("Write of one did not clear the timer bit.");

  a_irq_merge: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    ##1 CPU_IRQ_OUT == $past(gen_ff && (|(pend_vec & cfg_ff))))
    else $error("Processor request does not match enabled pending bits.");

  a_reg_pull_low: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) s_sleep_pull |=> s_line_low)
    else $error("Regulator line not pulled low in deep sleep.");

  a_reg_release: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) !DEEP_SLEEP_IN |=> oe_n_ff)
    else $error("Regulator line not released when awake.");

  a_status_rdclr: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    rd_acc && hit_stat && stat_set == RST_STAT |=> (stat_ff & $past(prdata_ff[ST_W-1:0])) == 3'h0)
    else $error("Status read did not clear returned bits.");

  // Refused access: an unmapped setup answers with an error and zero data.
  sequence s_bad_setup;
    setup && !pready_ff && !mapped;
  endsequence

  sequence s_err_reply;
    pready_ff && pslverr_ff && prdata_ff == 32'h00000000;
  endsequence

  // Software trigger repeat: a second write while the bit is still pending.
  sequence s_sw_repeat;
    sw_pulse && pend_vec[BIT_SW] && cfg_ff[BIT_SW];
  endsequence

  sequence s_sw_missed;
    miss_vec[BIT_SW] && pend_vec[BIT_SW] && stat_ff[ST_MISS_SET];
  endsequence

  a_unmapped_err: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) s_bad_setup |=> s_err_reply)
    else $error("Unmapped access was not refused.");

  a_sw_repeat_miss: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) s_sw_repeat |=> s_sw_missed)
    else $error("Repeated trigger did not record a software miss.");

  // Source pulses and the write-one acknowledge rules.
  a_pulse_sets_pend: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) SRC_EVENT_IN[BIT_ADC] |=> pend_vec[BIT_ADC])
    else $error("Converter pulse did not set its pending bit.");

  a_zero_keeps_pend: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    wr_acc && hit_pend && !wd[BIT_WDOG] && pend_vec[BIT_WDOG] |=> pend_vec[BIT_WDOG])
    else $error("Write of zero cleared a pending bit.");

  a_app_sec_kept: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    APP_MODE_IN && wr_acc && hit_pend && pend_vec[BIT_SEC] |=> pend_vec[BIT_SEC])
    else $error("Application write cleared the security pending bit.");

  a_serial_miss_clr: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    APP_MODE_IN && wr_acc && hit_miss && wd[BIT_SC1] && !miss_hit[BIT_SC1]
    |=> !miss_vec[BIT_SC1])
    else $error("Application write did not clear a serial missed bit.");

  // Gating of the outputs: global enable, status mask and pin select.
  a_global_gate: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) !gen_ff |=> !cpu_irq_ff)
    else $error("Processor request raised with the global enable off.");

  a_int_masked: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) (stat_ff & smask_ff) == RST_STAT |=> !int_ff)
    else $error("Status interrupt raised with no unmasked status bit.");

  a_pin_sel_off: assert property (
    @(posedge CLOCK_IN) disable iff (SRST_IN) !alt_en_ff |=> pin_sel_ff == {NGPIO{1'b0}})
    else $error("Regulator pin selected with the alternate function off.");

endmodule

// File: bench/icx_cpu_model.sv
// Processor core stand-in that counts entries on the merged interrupt request.
`timescale 1ns/10ps
module icx_cpu_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       irq_in,
  output logic      [7:0] entry_cnt_out
);
  logic irq_d_ff;

  // Each rising edge of the request is one interrupt entry of the core.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_d_ff      <= 1'b0;
      entry_cnt_out <= 8'h00;
    end else begin
      irq_d_ff <= irq_in;
      if (irq_in && !irq_d_ff) begin
        entry_cnt_out <= entry_cnt_out + 8'h01;
      end
    end
  end
endmodule

// File: bench/icx_top_bench.sv
// Self-checking bench for the pending, missed and trigger flags of the block.
`timescale 1ns/10ps
module icx_top_bench;
  import icx_pkg::*;
  logic             clk;
  logic             srst;
  icx_apb_req_t     req;
  icx_apb_rsp_t     rsp;
  logic [NSRC-1:0]  src;
  logic             app_mode;
  logic             deep_sleep;
  logic             cpu_irq;
  logic             int_irq;
  logic             reg_en;
  logic             reg_en_oe_n;
  logic [NGPIO-1:0] pin_sel;
  logic [7:0]       entries;
  logic [7:0]       entries0;
  logic [31:0]      rd;
  logic             err;
  wire              reg_en_wire;
  int               failures;
  int               total_checks;

  // The board pull-up raises the line whenever the block releases it.
  assign reg_en_wire = reg_en_oe_n ? 1'b1 : reg_en;

  icx_top dut (
    .CLOCK_IN           (clk),
    .SRST_IN            (srst),
    .APB_REQ_IN         (req),
    .APB_RSP_OUT        (rsp),
    .SRC_EVENT_IN       (src),
    .APP_MODE_IN        (app_mode),
    .DEEP_SLEEP_IN      (deep_sleep),
    .CPU_IRQ_OUT        (cpu_irq),
    .INT_OUT            (int_irq),
    .REG_EN_OUT         (reg_en),
    .REG_EN_OE_N_OUT    (reg_en_oe_n),
    .REG_EN_PIN_SEL_OUT (pin_sel)
  );

  icx_cpu_model cpu (
    .clk_in        (clk),
    .srst_in       (srst),
    .irq_in        (cpu_irq),
    .entry_cnt_out (entries)
  );

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= addr;
    req.pwdata  <= wdata;
    @(posedge clk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait for a slave that never answers.
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [31:0] wdata);
    apb(1'b1, addr, wdata);
  endtask

  task automatic rdchk(input string name, input logic [ADDR_W-1:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(name, rd, exp);
  endtask

  // One-cycle source pulse on the given bits.
  task automatic pulse(input logic [NSRC-1:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= '0;
  endtask

  // Waits a few edges and leaves the edge's updates time to land.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up;
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    req = '0;
    src = '0;
    app_mode = 1'b0;
    deep_sleep = 1'b0;
    srst = 1'b1;
    failures = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rdchk("pend rst", ADDR_PEND, 32'h0);
    rdchk("miss rst", ADDR_MISS, 32'h0);
    rdchk("swt rst", ADDR_SWT, 32'h0);
    check("oe_n rst", 32'(reg_en_oe_n), 32'h1);
    // Every source fires; bit 1 only follows the trigger and bit 0 stays zero.
    pulse(16'hFFFF);
    rdchk("pend all", ADDR_PEND, 32'h0000FFFC);
    wr(ADDR_PEND, 32'h00000004);
    rdchk("pend w1c", ADDR_PEND, 32'h0000FFF8);
    wr(ADDR_CFG, 32'h0000FFFE);
    pulse(16'hFFFF);
    rdchk("miss all", ADDR_MISS, 32'h0000EFF8);
    // Application mode may only clear timer, GPIO, converter and serial bits.
    @(posedge clk);
    app_mode <= 1'b1;
    wr(ADDR_PEND, 32'h0000FFFF);
    rdchk("pend app", ADDR_PEND, 32'h0000FFFC & ~32'h3860);
    wr(ADDR_MISS, 32'h0000FFFF);
    rdchk("miss app", ADDR_MISS, 32'h0000EFF8 & ~32'h3860);
    @(posedge clk);
    app_mode <= 1'b0;
    wr(ADDR_PEND, 32'h0000FFFF);
    wr(ADDR_MISS, 32'h0000FFFF);
    rdchk("pend clr", ADDR_PEND, 32'h0);
    rdchk("miss clr", ADDR_MISS, 32'h0);
    // A timer event lands on the edge that takes its acknowledge.
    pulse(16'h2000);
    fork
      wr(ADDR_PEND, 32'h00002000);
      begin
        repeat (2) @(posedge clk);
        src <= 16'h2000;
        @(posedge clk);
        src <= '0;
      end
    join
    rdchk("pend clash", ADDR_PEND, 32'h00002000);
    rdchk("miss clash", ADDR_MISS, 32'h00002000);
    wr(ADDR_PEND, 32'h0000FFFF);
    wr(ADDR_MISS, 32'h0000FFFF);
    // Software trigger stores any value and raises the software event.
    wr(ADDR_SWT, 32'h0000A5C3);
    rdchk("swt val", ADDR_SWT, 32'h0000A5C3);
    rdchk("pend sw", ADDR_PEND, 32'h00000002);
    wr(ADDR_SWT, 32'h00000000);
    rdchk("miss sw", ADDR_MISS, 32'h00000002);
    // Global enable gates the merged request to the core.
    entries0 = entries;
    wr(ADDR_GEN, 32'h1);
    tick(3);
    check("irq on", 32'(cpu_irq), 32'h1);
    check("entries", 32'(entries), 32'(entries0 + 8'h01));
    wr(ADDR_GEN, 32'h0);
    tick(3);
    check("irq off", 32'(cpu_irq), 32'h0);
    // Status interrupt: masked, unmasked, cleared by read, raised again.
    check("int masked", 32'(int_irq), 32'h0);
    wr(ADDR_SMASK, 32'h7);
    tick(3);
    check("int on", 32'(int_irq), 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("stat rd", rd, 32'h00000007);
    tick(3);
    check("int clr", 32'(int_irq), 32'h0);
    pulse(16'h0020);
    tick(3);
    check("int new", 32'(int_irq), 32'h1);
    // Regulator enable on GPIO pin 3 during deep sleep.
    wr(ADDR_REGC, 32'h00000031);
    @(posedge clk);
    deep_sleep <= 1'b1;
    tick(3);
    check("oe_n sleep", 32'(reg_en_oe_n), 32'h0);
    check("line sleep", 32'(reg_en_wire), 32'h0);
    check("pin sel", 32'(pin_sel), 32'h00000008);
    @(posedge clk);
    deep_sleep <= 1'b0;
    tick(3);
    check("line awake", 32'(reg_en_wire), 32'h1);
    // Unmapped address is refused.
    apb(1'b0, 20'h10000, 32'h0);
    check("slverr", 32'(err), 32'h1);
    check("rd unmapped", rd, 32'h0);
    wrap_up();
  end
endmodule
